// [hdl/cmpctl_defs.svh]
// Constants for the comparator control block: offsets, field positions, codes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CMPCTL_DEFS_SVH
`define CMPCTL_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define CMPCTL_CTRL_OFFSET    8'h50
`define CMPCTL_PINDIS_OFFSET  8'h7F
`define CMPCTL_IO_BIAS        8'h20
`define CMPCTL_IO_LIMIT       8'h60
`define CMPCTL_READ_IDLE      8'h00

// ****************************************
// Control and status fields
// ****************************************
`define CMPCTL_POWER_OFF_BIT  7
`define CMPCTL_BANDGAP_BIT    6
`define CMPCTL_RESULT_BIT     5
`define CMPCTL_FLAG_BIT       4
`define CMPCTL_IRQ_EN_BIT     3
`define CMPCTL_ROUTE_BIT      2
`define CMPCTL_MODE_HI        1
`define CMPCTL_MODE_LO        0
`define CMPCTL_POS_BUF_BIT    0
`define CMPCTL_NEG_BUF_BIT    1

// ****************************************
// Reset values and event mode codes
// ****************************************
`define CMPCTL_RESET_BIT      1'b0
`define CMPCTL_RESET_MODE     2'h0
`define CMPCTL_RESET_CHANNEL  3'h0
`define CMPCTL_MODE_TOGGLE    2'h0
`define CMPCTL_MODE_RESERVED  2'h1
`define CMPCTL_MODE_FALLING   2'h2
`define CMPCTL_MODE_RISING    2'h3

`endif

// [hdl/cmpctl_pkg.sv]
// Types shared by the comparator control block.
// Assumes the constants header is on the include path.
`include "cmpctl_defs.svh"

package cmpctl_pkg;

  typedef logic [7:0] cmpctl_byte_t;

  typedef enum logic [1:0] {
    CMPCTL_TOGGLE   = `CMPCTL_MODE_TOGGLE,
    CMPCTL_RESERVED = `CMPCTL_MODE_RESERVED,
    CMPCTL_FALLING  = `CMPCTL_MODE_FALLING,
    CMPCTL_RISING   = `CMPCTL_MODE_RISING
  } cmpctl_mode_e;

endpackage : cmpctl_pkg

// [hdl/cmpctl_sync.sv]
// Two-stage synchroniser for the raw comparator level.
// Assumes one system clock and synchronous active-high reset.
`include "cmpctl_defs.svh"

module cmpctl_sync (
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic i_level,
  output logic      o_level
);

  logic stage1_q;

  // First stage is read only by the second
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      stage1_q <= `CMPCTL_RESET_BIT;
      o_level  <= `CMPCTL_RESET_BIT;
    end else begin
      stage1_q <= i_level;
      o_level  <= stage1_q;
    end
  end

endmodule : cmpctl_sync

// [hdl/cmpctl_event.sv]
// Edge detector on the synchronised comparator level, per selected mode.
// Assumes the level input is already in the system clock domain.
`include "cmpctl_defs.svh"

module cmpctl_event (
  input  wire logic                 i_clock,
  input  wire logic                 i_reset,
  input  wire logic                 i_level,
  input  wire cmpctl_pkg::cmpctl_mode_e i_mode,
  output logic                      o_event
);

  logic prev_q;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      prev_q <= `CMPCTL_RESET_BIT;
    end else begin
      prev_q <= i_level;
    end
  end

  // Reserved code never matches
  always_comb begin
    unique case (i_mode)
      cmpctl_pkg::CMPCTL_TOGGLE:   o_event = i_level ^ prev_q;
      cmpctl_pkg::CMPCTL_RESERVED: o_event = 1'b0;
      cmpctl_pkg::CMPCTL_FALLING:  o_event = prev_q & ~i_level;
      cmpctl_pkg::CMPCTL_RISING:   o_event = ~prev_q & i_level;
    endcase
  end

endmodule : cmpctl_event

// [hdl/cmpctl_top.sv]
// Comparator control: input selection, result sync, events, pin buffer gating.
// Assumes the analog comparator, converter and timer capture sit outside,
// and the core drives the I/O register port synchronous to i_clock.
`include "cmpctl_defs.svh"

module cmpctl_top (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_io_addr,
  input  wire logic        i_io_space,
  input  wire logic        i_io_write,
  input  wire logic        i_io_read,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  input  wire logic        i_compare_raw,
  input  wire logic        i_negative_mux_enable,
  input  wire logic        i_converter_enable,
  input  wire logic        i_converter_power_reduce,
  input  wire logic [2:0]  i_channel_select_low,
  input  wire logic        i_global_irq_enable,
  input  wire logic        i_irq_vector_taken,
  input  wire logic        i_positive_pin_digital,
  input  wire logic        i_negative_pin_digital,
  output logic             o_compare_result,
  output logic             o_comparator_power_off,
  output logic             o_positive_bandgap_sel,
  output logic             o_negative_from_channel,
  output logic      [2:0]  o_negative_channel,
  output logic             o_irq_request,
  output logic             o_capture_input,
  output logic             o_positive_pin_buffer_off,
  output logic             o_negative_pin_buffer_off,
  output logic             o_positive_pin_read,
  output logic             o_negative_pin_read
);

  // ****************************************
  // Address decode
  // ****************************************
  // I/O-space alias exists only for the low window below the extended area
  function automatic logic cmpctl_hit(input logic [7:0] addr, input logic io_space, input logic [7:0] data_off);
    logic hit;
    hit = 1'b0;
    if (io_space) begin
      hit = (data_off < `CMPCTL_IO_LIMIT) && (addr == (data_off - `CMPCTL_IO_BIAS));
    end else begin
      hit = (addr == data_off);
    end
    return hit;
  endfunction : cmpctl_hit

  logic                      ctrl_hit;
  logic                      pindis_hit;
  logic                      ctrl_write;
  logic                      pindis_write;
  logic                      raw_eff;
  logic                      event_hit;
  logic                      flag_q;
  logic                      irq_en_q;
  logic                      route_q;
  logic                      bandgap_q;
  logic                      power_off_q;
  logic [1:0]                buf_off_q;
  logic [1:0]                pin_read_q;
  logic [1:0]                pin_digital;
  cmpctl_pkg::cmpctl_mode_e  mode_q;
  cmpctl_pkg::cmpctl_byte_t  ctrl_view;
  cmpctl_pkg::cmpctl_byte_t  pindis_view;
  cmpctl_pkg::cmpctl_byte_t  rdata_d;

  assign ctrl_hit     = cmpctl_hit(i_io_addr, i_io_space, `CMPCTL_CTRL_OFFSET);
  assign pindis_hit   = cmpctl_hit(i_io_addr, i_io_space, `CMPCTL_PINDIS_OFFSET);
  assign ctrl_write   = i_io_write & ctrl_hit;
  assign pindis_write = i_io_write & pindis_hit;

  // ****************************************
  // Result path
  // ****************************************
  // Powered-off comparator reads low; the step can raise an event
  assign raw_eff = i_compare_raw & ~power_off_q;

  cmpctl_sync u_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_level (raw_eff),
    .o_level (o_compare_result)
  );

  cmpctl_event u_event (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_level (o_compare_result),
    .i_mode  (mode_q),
    .o_event (event_hit)
  );

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      power_off_q <= `CMPCTL_RESET_BIT;
      bandgap_q   <= `CMPCTL_RESET_BIT;
      irq_en_q    <= `CMPCTL_RESET_BIT;
      route_q     <= `CMPCTL_RESET_BIT;
      mode_q      <= cmpctl_pkg::cmpctl_mode_e'(`CMPCTL_RESET_MODE);
    end else if (ctrl_write) begin
      power_off_q <= i_io_wdata[`CMPCTL_POWER_OFF_BIT];
      bandgap_q   <= i_io_wdata[`CMPCTL_BANDGAP_BIT];
      irq_en_q    <= i_io_wdata[`CMPCTL_IRQ_EN_BIT];
      route_q     <= i_io_wdata[`CMPCTL_ROUTE_BIT];
      mode_q      <= cmpctl_pkg::cmpctl_mode_e'(i_io_wdata[`CMPCTL_MODE_HI:`CMPCTL_MODE_LO]);
    end
  end

  // Set beats any clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      flag_q <= `CMPCTL_RESET_BIT;
    end else if (event_hit) begin
      flag_q <= 1'b1;
    end else if (i_irq_vector_taken || (ctrl_write && i_io_wdata[`CMPCTL_FLAG_BIT])) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_irq_request <= `CMPCTL_RESET_BIT;
    end else begin
      o_irq_request <= flag_q & irq_en_q & i_global_irq_enable;
    end
  end

  // Timer front end does its own filtering and edge choice
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_capture_input <= `CMPCTL_RESET_BIT;
    end else begin
      o_capture_input <= route_q & o_compare_result;
    end
  end

  // ****************************************
  // Input selection
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_negative_from_channel <= `CMPCTL_RESET_BIT;
      o_negative_channel      <= `CMPCTL_RESET_CHANNEL;
    end else begin
      o_negative_from_channel <= i_negative_mux_enable & ~i_converter_enable
                                 & ~i_converter_power_reduce;
      o_negative_channel      <= i_channel_select_low;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_positive_bandgap_sel <= `CMPCTL_RESET_BIT;
      o_comparator_power_off <= `CMPCTL_RESET_BIT;
    end else begin
      o_positive_bandgap_sel <= ctrl_write ? i_io_wdata[`CMPCTL_BANDGAP_BIT] : bandgap_q;
      o_comparator_power_off <= ctrl_write ? i_io_wdata[`CMPCTL_POWER_OFF_BIT] : power_off_q;
    end
  end

  // ****************************************
  // Pin digital buffers
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      buf_off_q <= {2{`CMPCTL_RESET_BIT}};
    end else if (pindis_write) begin
      buf_off_q[`CMPCTL_POS_BUF_BIT] <= i_io_wdata[`CMPCTL_POS_BUF_BIT];
      buf_off_q[`CMPCTL_NEG_BUF_BIT] <= i_io_wdata[`CMPCTL_NEG_BUF_BIT];
    end
  end

  assign pin_digital[`CMPCTL_POS_BUF_BIT] = i_positive_pin_digital;
  assign pin_digital[`CMPCTL_NEG_BUF_BIT] = i_negative_pin_digital;

  for (genvar g = 0; g < 2; g++) begin : g_pin
    always_ff @(posedge i_clock) begin
      if (i_reset) begin
        pin_read_q[g] <= `CMPCTL_RESET_BIT;
      end else begin
        pin_read_q[g] <= pin_digital[g] & ~buf_off_q[g];
      end
    end
  end

  assign o_positive_pin_read       = pin_read_q[`CMPCTL_POS_BUF_BIT];
  assign o_negative_pin_read       = pin_read_q[`CMPCTL_NEG_BUF_BIT];
  assign o_positive_pin_buffer_off = buf_off_q[`CMPCTL_POS_BUF_BIT];
  assign o_negative_pin_buffer_off = buf_off_q[`CMPCTL_NEG_BUF_BIT];

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    ctrl_view                             = `CMPCTL_READ_IDLE;
    ctrl_view[`CMPCTL_POWER_OFF_BIT]      = power_off_q;
    ctrl_view[`CMPCTL_BANDGAP_BIT]        = bandgap_q;
    ctrl_view[`CMPCTL_RESULT_BIT]         = o_compare_result;
    ctrl_view[`CMPCTL_FLAG_BIT]           = flag_q;
    ctrl_view[`CMPCTL_IRQ_EN_BIT]         = irq_en_q;
    ctrl_view[`CMPCTL_ROUTE_BIT]          = route_q;
    ctrl_view[`CMPCTL_MODE_HI:`CMPCTL_MODE_LO] = mode_q;
    pindis_view                           = `CMPCTL_READ_IDLE;
    pindis_view[`CMPCTL_NEG_BUF_BIT:`CMPCTL_POS_BUF_BIT] = buf_off_q;
    rdata_d                               = `CMPCTL_READ_IDLE;
    if (ctrl_hit) begin
      rdata_d = ctrl_view;
    end else if (pindis_hit) begin
      rdata_d = pindis_view;
    end
  end

  // Unmapped reads and idle cycles return zero
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_io_rdata <= `CMPCTL_READ_IDLE;
    end else begin
      o_io_rdata <= i_io_read ? rdata_d : `CMPCTL_READ_IDLE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sync_delay_a: assert property (
    !$past(i_reset, 1) && !$past(i_reset, 2) |-> o_compare_result == $past(raw_eff, 2))
    else $error("Result not two cycles behind comparator");

  result_level_a: assert property (
    raw_eff [*3] |-> o_compare_result)
    else $error("Result low while comparator high");

  neg_channel_a: assert property (
    i_negative_mux_enable && !i_converter_enable && !i_converter_power_reduce
    |=> o_negative_from_channel && o_negative_channel == $past(i_channel_select_low))
    else $error("Channel not selected for negative input");

  neg_pin_a: assert property (
    !i_negative_mux_enable || i_converter_enable |=> !o_negative_from_channel)
    else $error("Negative pin not selected");

  mux_power_a: assert property (
    i_converter_power_reduce |=> !o_negative_from_channel)
    else $error("Mux used while converter power reduced");

  bandgap_sel_a: assert property (
    ctrl_write |=> o_positive_bandgap_sel == $past(i_io_wdata[`CMPCTL_BANDGAP_BIT]))
    else $error("Bandgap select did not follow write");

  power_off_a: assert property (
    ctrl_write && i_io_wdata[`CMPCTL_POWER_OFF_BIT] |=> o_comparator_power_off ##2 !o_compare_result [*2])
    else $error("Power-off write not effective");

  reserved_mode_a: assert property (
    mode_q == cmpctl_pkg::CMPCTL_RESERVED && !flag_q && !ctrl_write |=> !flag_q)
    else $error("Flag set in reserved mode");

  rising_flag_a: assert property (
    mode_q == cmpctl_pkg::CMPCTL_RISING && $rose(o_compare_result) |=> flag_q)
    else $error("Rising edge did not set flag");

  flag_clear_a: assert property (
    flag_q && i_irq_vector_taken && !event_hit |=> !flag_q)
    else $error("Vector did not clear flag");

  irq_request_a: assert property (
    flag_q && irq_en_q && i_global_irq_enable |=> o_irq_request)
    else $error("Interrupt not requested");

  route_off_a: assert property (
    !route_q |=> !o_capture_input)
    else $error("Capture driven while routing off");

  io_alias_a: assert property (
    i_io_read && i_io_space && i_io_addr == (`CMPCTL_CTRL_OFFSET - `CMPCTL_IO_BIAS)
    |=> o_io_rdata[`CMPCTL_RESULT_BIT] == $past(o_compare_result))
    else $error("I/O alias read wrong");

  pin_read_a: assert property (
    buf_off_q[`CMPCTL_POS_BUF_BIT] |=> !o_positive_pin_read)
    else $error("Pin read not forced low");

endmodule : cmpctl_top

// [testbench/cmpctl_analog_model.sv]
// Behavioural model of the analog inputs and the timer capture front end.
// Assumes the control block's selection outputs drive it directly.
module cmpctl_analog_model #(
  parameter int BANDGAP_MV     = 1100,
  parameter bit CAPTURE_IRQ_ON = 1'b1
) (
  input  wire logic        i_clock,
  input  wire logic        i_power_off,
  input  wire logic        i_bandgap_sel,
  input  wire logic        i_from_channel,
  input  wire logic [2:0]  i_channel,
  input  wire logic [11:0] i_positive_mv,
  input  wire logic [11:0] i_negative_mv,
  input  wire logic        i_capture_input,
  output logic             o_compare_raw,
  output logic      [7:0]  o_capture_count
);
  timeunit 1ns;
  timeprecision 1ps;

  int   pos_mv;
  int   neg_mv;
  logic junk_q = 1'b0;
  logic cap_q  = 1'b0;
  logic [7:0] count_q = 8'h00;

  // ****************************************
  // Comparator inputs
  // ****************************************
  always_comb begin
    pos_mv = i_bandgap_sel ? BANDGAP_MV : int'(i_positive_mv);
    neg_mv = i_from_channel ? 200 + 100 * int'(i_channel) : int'(i_negative_mv);
  end

  // Powered off gives no real answer, so a changing pattern
  always @(posedge i_clock) junk_q <= ~junk_q;
  assign o_compare_raw = i_power_off ? junk_q : (pos_mv > neg_mv);

  // ****************************************
  // Timer capture side
  // ****************************************
  assign o_capture_count = count_q;
  always @(posedge i_clock) begin
    cap_q <= i_capture_input;
    if (CAPTURE_IRQ_ON && i_capture_input && !cap_q) begin
      count_q <= count_q + 8'h01;
    end
  end
endmodule : cmpctl_analog_model

// [testbench/comparator_control_logic_tb.sv]
// Self-checking bench for the comparator control block.
// Assumes the analog model stands in for the comparator and capture unit.
module comparator_control_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clock = 1'b0, i_reset = 1'b1, i_io_space = 1'b0, i_io_write = 1'b0, i_io_read = 1'b0;
  logic [7:0] i_io_addr = 8'h00, i_io_wdata = 8'h00, o_io_rdata, cap_count;
  logic i_compare_raw, mux_en = 1'b0, conv_en = 1'b0, pwr_red = 1'b0, glob = 1'b0, vtaken = 1'b0;
  logic [2:0] chan = 3'h0, o_negative_channel;
  logic pos_dig = 1'b0, neg_dig = 1'b0, o_compare_result, o_comparator_power_off, o_positive_bandgap_sel;
  logic o_negative_from_channel, o_irq_request, o_capture_input, o_pos_off, o_neg_off, o_pos_rd, o_neg_rd;
  logic [11:0] pos_mv = 12'h000, neg_mv = 12'h000;
  int failures = 0, n_tests = 0, cycles = 0;

  always #10 i_clock = ~i_clock;

  cmpctl_top dut (.i_clock(i_clock), .i_reset(i_reset), .i_io_addr(i_io_addr), .i_io_space(i_io_space),
    .i_io_write(i_io_write), .i_io_read(i_io_read), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .i_compare_raw(i_compare_raw), .i_negative_mux_enable(mux_en), .i_converter_enable(conv_en),
    .i_converter_power_reduce(pwr_red), .i_channel_select_low(chan), .i_global_irq_enable(glob),
    .i_irq_vector_taken(vtaken), .i_positive_pin_digital(pos_dig), .i_negative_pin_digital(neg_dig),
    .o_compare_result(o_compare_result), .o_comparator_power_off(o_comparator_power_off),
    .o_positive_bandgap_sel(o_positive_bandgap_sel), .o_negative_from_channel(o_negative_from_channel),
    .o_negative_channel(o_negative_channel), .o_irq_request(o_irq_request), .o_capture_input(o_capture_input),
    .o_positive_pin_buffer_off(o_pos_off), .o_negative_pin_buffer_off(o_neg_off),
    .o_positive_pin_read(o_pos_rd), .o_negative_pin_read(o_neg_rd));

  cmpctl_analog_model model (.i_clock(i_clock), .i_power_off(o_comparator_power_off),
    .i_bandgap_sel(o_positive_bandgap_sel), .i_from_channel(o_negative_from_channel),
    .i_channel(o_negative_channel), .i_positive_mv(pos_mv), .i_negative_mv(neg_mv),
    .i_capture_input(o_capture_input), .o_compare_raw(i_compare_raw), .o_capture_count(cap_count));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(negedge i_clock);
  endtask : step

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] addr, input logic space, input logic [7:0] data);
    @(negedge i_clock);
    i_io_addr = addr; i_io_space = space; i_io_wdata = data; i_io_write = 1'b1;
    @(negedge i_clock);
    i_io_write = 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] addr, input logic space, output logic [7:0] data);
    @(negedge i_clock);
    i_io_addr = addr; i_io_space = space; i_io_read = 1'b1;
    @(negedge i_clock);
    i_io_read = 1'b0;
    data = o_io_rdata;
  endtask : bus_read

  task automatic volts(input logic [11:0] p, input logic [11:0] n, input int wait_n);
    @(negedge i_clock);
    pos_mv = p; neg_mv = n;
    step(wait_n);
  endtask : volts

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_map;
    logic [7:0] d;
    bus_read(8'h50, 1'b0, d); check(d, 8'h00);
    bus_read(8'h7F, 1'b0, d); check(d, 8'h00);
    bus_write(8'h30, 1'b1, 8'h2B);
    bus_read(8'h50, 1'b0, d); check(d, 8'h0B);
    bus_read(8'h5F, 1'b1, d); check(d, 8'h00);
    bus_write(8'h51, 1'b0, 8'hFF);
    bus_read(8'h51, 1'b0, d); check(d, 8'h00);
    bus_write(8'h50, 1'b0, 8'h00);
    $display("test map done");
  endtask : t_map

  task automatic t_result;
    logic [7:0] d;
    volts(12'd800, 12'd500, 1); check(o_compare_result, 8'h00);
    step(1); check(o_compare_result, 8'h01);
    step(1);
    bus_read(8'h30, 1'b1, d); check(d, 8'h30);
    bus_write(8'h50, 1'b0, 8'h10);
    bus_read(8'h50, 1'b0, d); check(d, 8'h20);
    $display("test result done");
  endtask : t_result

  task automatic t_modes;
    logic [7:0] d;
    for (int m = 0; m < 4; m++) begin
      volts(12'd300, 12'd500, 4);
      bus_write(8'h50, 1'b0, 8'h10 | 8'(m));  // Mode changed with interrupt off
      volts(12'd800, 12'd500, 4);
      bus_read(8'h50, 1'b0, d); check(8'(d[4]), 8'((m == 0) || (m == 3)));
      bus_write(8'h50, 1'b0, 8'h10 | 8'(m));
      volts(12'd300, 12'd500, 4);
      bus_read(8'h50, 1'b0, d); check(8'(d[4]), 8'((m == 0) || (m == 2)));
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_irq;
    logic [7:0] d;
    bus_write(8'h50, 1'b0, 8'h13);
    glob = 1'b1;
    volts(12'd800, 12'd500, 4); check(o_irq_request, 8'h00);
    bus_write(8'h50, 1'b0, 8'h0B); step(1); check(o_irq_request, 8'h01);
    glob = 1'b0; step(2); check(o_irq_request, 8'h00);
    glob = 1'b1; step(2); check(o_irq_request, 8'h01);
    bus_read(8'h50, 1'b0, d); check(8'(d[4]), 8'h01);
    vtaken = 1'b1; step(1); vtaken = 1'b0; step(2);
    check(o_irq_request, 8'h00);
    volts(12'd300, 12'd500, 2);
    volts(12'd800, 12'd500, 5); check(o_irq_request, 8'h01);
    bus_write(8'h50, 1'b0, 8'h1B); step(2); check(o_irq_request, 8'h00);
    bus_write(8'h50, 1'b0, 8'h03);  // Interrupt off before later changes
    $display("test irq done");
  endtask : t_irq

  task automatic t_select;
    logic expect_ch;
    for (int i = 0; i < 64; i++) begin
      @(negedge i_clock);
      {mux_en, conv_en, pwr_red, chan} = 6'(i);
      step(2);
      expect_ch = mux_en && !conv_en && !pwr_red;
      check(o_negative_from_channel, 8'(expect_ch));
      if (expect_ch) check(o_negative_channel, 8'(chan));
    end
    @(negedge i_clock);
    {mux_en, conv_en, pwr_red, chan} = 6'b100010;
    volts(12'd450, 12'd900, 5); check(o_compare_result, 8'h01);
    chan = 3'h3; step(5); check(o_compare_result, 8'h00);
    mux_en = 1'b0;
    $display("test select done");
  endtask : t_select

  task automatic t_power;
    logic [7:0] d;
    logic [7:0] c0;
    volts(12'd300, 12'd500, 2);
    bus_write(8'h50, 1'b0, 8'h40); check(o_positive_bandgap_sel, 8'h01);
    step(4); check(o_compare_result, 8'h01);
    bus_write(8'h50, 1'b0, 8'h04); step(4);
    check(o_capture_input, 8'h00);
    c0 = cap_count;
    volts(12'd800, 12'd500, 5); check(o_capture_input, 8'h01);
    check(cap_count, c0 + 8'h01);
    bus_write(8'h50, 1'b0, 8'h00); step(2); check(o_capture_input, 8'h00);
    bus_write(8'h50, 1'b0, 8'h80); check(o_comparator_power_off, 8'h01);
    bus_read(8'h50, 1'b0, d); check(d & 8'hC0, 8'h80);
    bus_write(8'h50, 1'b0, 8'h10); check(o_comparator_power_off, 8'h00);
    $display("test power done");
  endtask : t_power

  task automatic t_pins;
    logic [7:0] d;
    pos_dig = 1'b1; neg_dig = 1'b1; step(2);
    check({o_pos_rd, o_neg_rd}, 8'h03);
    bus_write(8'h7F, 1'b0, 8'hFF);  // Analog pins with buffers off
    bus_read(8'h7F, 1'b0, d); check(d, 8'h03);
    check({o_pos_off, o_neg_off, o_pos_rd, o_neg_rd}, 8'h0C);
    bus_write(8'h7F, 1'b0, 8'h01); step(1);
    check({o_pos_off, o_neg_off, o_pos_rd, o_neg_rd}, 8'h09);
    bus_write(8'h7F, 1'b0, 8'h00);
    $display("test pins done");
  endtask : t_pins

  task automatic t_reset;
    logic [7:0] d;
    volts(12'd300, 12'd500, 1);
    bus_write(8'h50, 1'b0, 8'hC4);  // Power changed with interrupt off
    bus_write(8'h7F, 1'b0, 8'h03);
    @(negedge i_clock);
    i_reset = 1'b1;
    step(2);
    check(o_comparator_power_off, 8'h00);
    i_reset = 1'b0;
    bus_read(8'h50, 1'b0, d); check(d, 8'h00);
    bus_read(8'h7F, 1'b0, d); check(d, 8'h00);
    check({o_pos_off, o_neg_off, o_positive_bandgap_sel, o_capture_input}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // ****************************************
  // Run control
  // ****************************************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    step(2);
    i_reset = 1'b0;
    t_map();
    t_result();
    t_modes();
    t_irq();
    t_select();
    t_power();
    t_pins();
    t_reset();
    wrap_up();
  end
endmodule : comparator_control_logic_tb
